/* File: hw/scc_ctl_regs.vh */
// Constants for the successive-approximation conversion control block
`ifndef SCC_CTL_REGS_VH
`define SCC_CTL_REGS_VH

`define SCC_RES_BITS 16
`define SCC_IDX_BITS 4
`define SCC_MSB_IDX 4'hf
`define SCC_MSB_MASK 16'h8000
`define SCC_CODE_MAX 16'hffff
`define SCC_CODE_MIN 16'h0000
`define SCC_CODE_ZERO 16'h0000

`define SCC_CLK_PERIOD_NS 5
`define SCC_TRIAL_NS_WARP 50
`define SCC_TRIAL_NS_NORMAL 60
`define SCC_TRIAL_NS_IMPULSE 80
`define SCC_TRIAL_MIN_CYC 4
`define SCC_ACQ_NS 250
`define SCC_STALE_MS 1
`define SCC_NS_PER_MS 1000000

`define SCC_MODE_NORMAL 2'h0
`define SCC_MODE_WARP 2'h1
`define SCC_MODE_IMPULSE 2'h2

`define SCC_ST_ACQ 2'h0
`define SCC_ST_TRIAL 2'h1
`define SCC_ST_FORM 2'h2

`define SCC_ADDR_CTRL 4'h0
`define SCC_ADDR_STATUS 4'h4
`define SCC_ADDR_RESULT 4'h8
`define SCC_CTRL_RESET 8'h00
`define SCC_STAT_BUSY 0
`define SCC_STAT_MODE_LO 1
`define SCC_STAT_MODE_HI 2
`define SCC_STAT_STALE 3
`define SCC_STAT_VALID 4

`endif

/* File: hw/scc_sar_step.v */
// One successive-approximation decision on the trial code
`timescale 1ns/1ps
`default_nettype none
`include "scc_ctl_regs.vh"

module scc_sar_step (
    input wire [15:0] code,
    input wire [3:0] bit_idx,
    input wire keep_bit,
    output wire [15:0] code_next
);
    wire [15:0] cur_mask;
    wire [15:0] low_mask;
    wire [15:0] decided;

    assign cur_mask = `SCC_MSB_MASK >> (`SCC_MSB_IDX - bit_idx);
    assign low_mask = cur_mask >> 1;
    // Drop the trial weight when the comparator says it overshot
    assign decided = keep_bit ? code : (code & ~cur_mask);
    assign code_next = decided | low_mask;
endmodule // scc_sar_step

`default_nettype wire

/* File: hw/scc_conversion_control.v */
// Conversion sequencer, coding and register port of the sampling converter
// Behaviour
// - A falling edge on convert_strobe_n ends acquisition, holds the input and starts converting.
// - Sixteen trials run MSB first, each at half the weight of the one before.
// - After the last trial the code is formed and busy then drops low.
// - The result belongs to the sample of the same strobe, with no pipeline latency.
// - Fastest mode trial timing (16 trials of 50 ns, 805 ns busy) supports throughput up to about 950 kSPS with 250 ns acquisition.
// - Both mode inputs low select the intermediate mode with no interval limit.
// - Low-power mode reduces power between conversions.
// - coding_select high gives straight binary, low gives two's complement.
// - Straight binary runs from 0000 through 8000 at midscale to FFFF.
// - Two's complement is straight binary with its top bit inverted.
// - Overrange input clamps to the largest code of the chosen coding.
// - Underrange input clamps to the smallest code of the chosen coding.
// - Low-power select high with fast select low selects low-power mode.
// - Reset high resets the block and aborts any conversion.
`timescale 1ns/1ps
`default_nettype none
`include "scc_ctl_regs.vh"

module scc_conversion_control #(
    parameter STALE_CYC = (`SCC_STALE_MS * `SCC_NS_PER_MS) / `SCC_CLK_PERIOD_NS,
    parameter ACQ_CYC = (`SCC_ACQ_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS
) (
    input wire ref_clk,
    input wire rst,
    input wire convert_strobe_n,
    input wire fast_select,
    input wire low_power_select,
    input wire coding_select,
    input wire cmp_above,
    input wire over_range,
    input wire under_range,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg busy,
    output reg [15:0] result,
    output reg result_valid,
    output reg [15:0] dac_code,
    output reg hold,
    output reg low_power,
    output reg result_stale
);
    // Integer arithmetic first, then cut on purpose to the counter widths
    localparam integer TRIAL_WARP_I = `SCC_TRIAL_NS_WARP / `SCC_CLK_PERIOD_NS;
    localparam integer TRIAL_NORMAL_I = `SCC_TRIAL_NS_NORMAL / `SCC_CLK_PERIOD_NS;
    localparam integer TRIAL_IMPULSE_I = `SCC_TRIAL_NS_IMPULSE / `SCC_CLK_PERIOD_NS;
    localparam integer TRIAL_MIN_I = `SCC_TRIAL_MIN_CYC;
    localparam integer STALE_I = STALE_CYC;
    localparam integer ACQ_I = ACQ_CYC;
    localparam [7:0] TRIAL_WARP = TRIAL_WARP_I[7:0];
    localparam [7:0] TRIAL_NORMAL = TRIAL_NORMAL_I[7:0];
    localparam [7:0] TRIAL_IMPULSE = TRIAL_IMPULSE_I[7:0];
    localparam [7:0] TRIAL_MIN = TRIAL_MIN_I[7:0];
    localparam [31:0] STALE_LIM = STALE_I[31:0];
    localparam [15:0] ACQ_LIM = ACQ_I[15:0];

    // Mode from the two select pins; both high is not a listed case
    function [1:0] mode_of;
        input fast;
        input lp;
        begin
            if (fast && !lp) begin
                mode_of = `SCC_MODE_WARP;
            end else if (lp && !fast) begin
                mode_of = `SCC_MODE_IMPULSE;
            end else begin
                mode_of = `SCC_MODE_NORMAL;
            end
        end
    endfunction

    function [7:0] trial_cyc;
        input [1:0] mode;
        input [7:0] extra;
        reg [7:0] base;
        reg [8:0] sum;
        begin
            base = TRIAL_NORMAL;
            sum = 9'h000;
            case (mode)
                `SCC_MODE_WARP: base = TRIAL_WARP;
                `SCC_MODE_IMPULSE: base = TRIAL_IMPULSE;
                default: base = TRIAL_NORMAL;
            endcase
            sum = {1'b0, base} + {1'b0, extra};
            if (sum[8]) begin
                trial_cyc = 8'hff;
            end else if (sum[7:0] < TRIAL_MIN) begin
                trial_cyc = TRIAL_MIN;
            end else begin
                trial_cyc = sum[7:0];
            end
        end
    endfunction

    // Two flops on every converter pin before any logic; the register port pins and rst are used without them
    reg cnv_s1_q, cnv_s2_q, cnv_s3_q;
    reg fast_s1_q, fast_s2_q;
    reg lp_s1_q, lp_s2_q;
    reg cod_s1_q, cod_s2_q;
    reg cmp_s1_q, cmp_s2_q;
    reg ovr_s1_q, ovr_s2_q;
    reg und_s1_q, und_s2_q;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnv_s1_q <= 1'b1;
            cnv_s2_q <= 1'b1;
            cnv_s3_q <= 1'b1;
            fast_s1_q <= 1'b0;
            fast_s2_q <= 1'b0;
            lp_s1_q <= 1'b0;
            lp_s2_q <= 1'b0;
            cod_s1_q <= 1'b1;
            cod_s2_q <= 1'b1;
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            ovr_s1_q <= 1'b0;
            ovr_s2_q <= 1'b0;
            und_s1_q <= 1'b0;
            und_s2_q <= 1'b0;
        end else begin
            cnv_s1_q <= convert_strobe_n;
            cnv_s2_q <= cnv_s1_q;
            cnv_s3_q <= cnv_s2_q;
            fast_s1_q <= fast_select;
            fast_s2_q <= fast_s1_q;
            lp_s1_q <= low_power_select;
            lp_s2_q <= lp_s1_q;
            cod_s1_q <= coding_select;
            cod_s2_q <= cod_s1_q;
            cmp_s1_q <= cmp_above;
            cmp_s2_q <= cmp_s1_q;
            ovr_s1_q <= over_range;
            ovr_s2_q <= ovr_s1_q;
            und_s1_q <= under_range;
            und_s2_q <= und_s1_q;
        end
    end

    reg [1:0] state_q;
    reg [1:0] mode_q;
    reg [3:0] idx_q;
    reg [7:0] cnt_q;
    reg [7:0] extra_q;
    reg [15:0] acq_q;
    reg [31:0] idle_q;
    reg ovr_q, und_q;

    wire [1:0] pin_mode;
    wire strobe_fall;
    wire auto_start;
    wire start;
    wire [15:0] step_code;

    assign pin_mode = mode_of(fast_s2_q, lp_s2_q);
    assign strobe_fall = cnv_s3_q && !cnv_s2_q;
    // Held-low strobe restarts by itself only in low-power mode
    assign auto_start = (pin_mode == `SCC_MODE_IMPULSE) && !cnv_s2_q && (acq_q >= ACQ_LIM);
    assign start = (state_q == `SCC_ST_ACQ) && (strobe_fall || auto_start);

    scc_sar_step u_step (
        .code(dac_code),
        .bit_idx(idx_q),
        .keep_bit(cmp_s2_q),
        .code_next(step_code)
    );

    // Code shaping: clamp first, then pick the coding
    function [15:0] form_code;
        input [15:0] raw;
        input ovr;
        input und;
        input binary;
        reg [15:0] sb;
        begin
            sb = raw;
            if (ovr) begin
                sb = `SCC_CODE_MAX;
            end else if (und) begin
                sb = `SCC_CODE_MIN;
            end
            if (binary) begin
                form_code = sb;
            end else begin
                form_code = sb ^ `SCC_MSB_MASK;
            end
        end
    endfunction

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Abort: everything back to acquisition, result cleared
            state_q <= `SCC_ST_ACQ;
            mode_q <= `SCC_MODE_NORMAL;
            idx_q <= `SCC_MSB_IDX;
            cnt_q <= 8'h00;
            acq_q <= 16'h0000;
            ovr_q <= 1'b0;
            und_q <= 1'b0;
            busy <= 1'b0;
            hold <= 1'b0;
            dac_code <= `SCC_CODE_ZERO;
            result <= `SCC_CODE_ZERO;
            result_valid <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            case (state_q)
                `SCC_ST_ACQ: begin
                    if (start) begin
                        state_q <= `SCC_ST_TRIAL;
                        mode_q <= pin_mode;
                        hold <= 1'b1;
                        busy <= 1'b1;
                        dac_code <= `SCC_MSB_MASK;
                        idx_q <= `SCC_MSB_IDX;
                        cnt_q <= trial_cyc(pin_mode, extra_q) - 8'h01;
                        ovr_q <= 1'b0;
                        und_q <= 1'b0;
                        acq_q <= 16'h0000;
                    end else if (acq_q < ACQ_LIM) begin
                        acq_q <= acq_q + 16'h0001;
                    end
                end
                `SCC_ST_TRIAL: begin
                    // Range flags are caught in every trial cycle; the form cycle does not sample them
                    ovr_q <= ovr_q | ovr_s2_q;
                    und_q <= und_q | und_s2_q;
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        dac_code <= step_code;
                        cnt_q <= trial_cyc(mode_q, extra_q) - 8'h01;
                        if (idx_q == 4'h0) begin
                            state_q <= `SCC_ST_FORM;
                        end else begin
                            idx_q <= idx_q - 4'h1;
                        end
                    end
                end
                `SCC_ST_FORM: begin
                    // Code and busy release land on one edge: no latency
                    result <= form_code(dac_code, ovr_q, und_q, cod_s2_q);
                    result_valid <= 1'b1;
                    busy <= 1'b0;
                    hold <= 1'b0;
                    state_q <= `SCC_ST_ACQ;
                end
                default: begin
                    state_q <= `SCC_ST_ACQ;
                    busy <= 1'b0;
                    hold <= 1'b0;
                end
            endcase
        end
    end

    // Low-power gating between conversions, and idle tracking for the warning
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_power <= 1'b0;
            idle_q <= 32'h00000000;
            result_stale <= 1'b1;
        end else begin
            low_power <= (pin_mode == `SCC_MODE_IMPULSE) && (state_q == `SCC_ST_ACQ) && !start;
            if (state_q != `SCC_ST_ACQ) begin
                idle_q <= 32'h00000000;
            end else if (idle_q < STALE_LIM) begin
                idle_q <= idle_q + 32'h00000001;
            end
            // Flag only; dropping the result is up to the host
            if (start) begin
                result_stale <= (pin_mode == `SCC_MODE_WARP) && (idle_q >= STALE_LIM);
            end
        end
    end

    // Register port: one-cycle write, read data in the following cycle
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extra_q <= `SCC_CTRL_RESET;
            reg_rdata <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == `SCC_ADDR_CTRL) begin
                extra_q <= reg_wdata[7:0];
            end
            if (reg_rd) begin
                case (reg_addr)
                    `SCC_ADDR_CTRL: reg_rdata <= {8'h00, extra_q};
                    `SCC_ADDR_STATUS: begin
                        reg_rdata <= 16'h0000;
                        reg_rdata[`SCC_STAT_BUSY] <= busy;
                        reg_rdata[`SCC_STAT_MODE_HI:`SCC_STAT_MODE_LO] <= pin_mode;
                        reg_rdata[`SCC_STAT_STALE] <= result_stale;
                        reg_rdata[`SCC_STAT_VALID] <= result_valid;
                    end
                    `SCC_ADDR_RESULT: reg_rdata <= result;
                    default: reg_rdata <= 16'h0000;
                endcase
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end
endmodule // scc_conversion_control

`default_nettype wire

/* File: dv/scc_conversion_control_chk.sv */
// Port checker for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module scc_conversion_control_chk (
    input wire ref_clk,
    input wire rst,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire busy,
    input wire hold,
    input wire [15:0] result,
    input wire result_valid,
    input wire [15:0] dac_code,
    input wire low_power
);
    reg [12:0] busy_cnt_q;
    wire [12:0] busy_cnt_d;
    assign busy_cnt_d = busy ? busy_cnt_q + 13'h1 : 13'h0;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 13'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    hold_busy_a: assert property (hold == busy)
        else $error("hold differs from busy");
    valid_fall_a: assert property ($fell(busy) |-> result_valid)
        else $error("no valid pulse as busy falls");
    valid_pulse_a: assert property (result_valid |-> !busy ##1 !result_valid)
        else $error("valid pulse malformed");
    result_hold_a: assert property (!result_valid |-> $stable(result))
        else $error("result moved without valid");
    msb_first_a: assert property ($rose(busy) |-> dac_code == 16'h8000)
        else $error("first trial is not the top bit");
    trial_count_a: assert property ($fell(busy) |-> busy_cnt_q[3:0] == 4'h1
        && busy_cnt_q >= 13'h0a1) else $error("busy length not sixteen trials");
    lp_idle_a: assert property (low_power |-> !busy)
        else $error("low power during conversion");
    reset_abort_a: assert property ($past(rst) |-> !busy && result == 16'h0)
        else $error("conversion survived reset");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data without read");
endmodule // scc_conversion_control_chk
bind scc_conversion_control scc_conversion_control_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .hold(hold), .result(result),
    .result_valid(result_valid), .dac_code(dac_code), .low_power(low_power));
`default_nettype wire

/* File: dv/scc_front_model.sv */
// Analog front model: comparator and range flags
`timescale 1ns/1ps
`default_nettype none
module scc_front_model (
    input wire logic [15:0] dac_code,
    input wire logic signed [17:0] level,
    output logic cmp_above,
    output logic over_range,
    output logic under_range
);
    // Settles at once, well inside a trial
    assign cmp_above = level >= $signed({2'b00, dac_code});
    assign over_range = level > 18'sh0ffff;
    assign under_range = level < 18'sh00000;
endmodule // scc_front_model
`default_nettype wire

/* File: dv/scc_conversion_control_bench.sv */
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module scc_conversion_control_bench;
    logic ref_clk, rst, strobe_n, fast, lp, coding, cmp, ovr, und, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, result, dac_code;
    logic busy, result_valid, hold, low_power, stale;
    logic signed [17:0] level;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    scc_conversion_control #(.STALE_CYC(50), .ACQ_CYC(8)) dut (.ref_clk(ref_clk), .rst(rst),
        .convert_strobe_n(strobe_n), .fast_select(fast), .low_power_select(lp),
        .coding_select(coding), .cmp_above(cmp), .over_range(ovr), .under_range(und),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .busy(busy), .result(result), .result_valid(result_valid),
        .dac_code(dac_code), .hold(hold), .low_power(low_power), .result_stale(stale));
    scc_front_model u_front (.dac_code(dac_code), .level(level), .cmp_above(cmp),
        .over_range(ovr), .under_range(und));
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg read", e, reg_rdata);
    endtask
    // Mode pins, coding, level, trial cycles, expected staleness
    task automatic conv(input logic f, l, c, input int v, t, input logic s);
        logic [15:0] e;
        int n;
        e = v > 65535 ? 16'hffff : v < 0 ? 16'h0000 : v[15:0];
        if (!c) e = e ^ 16'h8000;
        @(posedge ref_clk);
        fast <= f;
        lp <= l;
        coding <= c;
        level <= 18'(v);
        repeat (4) @(posedge ref_clk);
        strobe_n <= 1'b0;
        n = 0;
        while (!busy && n < 10) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("top trial", 16'h8000, dac_code);
        n = 0;
        while (busy && n < 5000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("busy cycles", 16'(16 * t + 1), 16'(n));
        chk("result", e, result);
        chk("valid", 16'h1, {15'h0, result_valid});
        chk("stale", {15'h0, s}, {15'h0, stale});
        @(posedge ref_clk);
        strobe_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("low power", {15'h0, l & ~f}, {15'h0, low_power});
        $display("conversion level %0d done", v);
    endtask
    task automatic t_regs();
        chk("stale at reset", 16'h1, {15'h0, stale});
        rd(4'h0, 16'h0000);
        rd(4'hc, 16'h0000);
        wr(4'h0, 16'h0005);
        rd(4'h0, 16'h0005);
        wr(4'h8, 16'hffff);
        rd(4'h8, 16'h0000);
        wr(4'h0, 16'h0000);
        rd(4'h4, 16'h0008);
        $display("register test done");
    endtask
    task automatic t_codes();
        conv(0, 0, 1, 0, 12, 0);
        conv(1, 0, 1, 32768, 10, 0);
        conv(0, 1, 1, 65535, 16, 0);
        conv(1, 1, 0, 0, 12, 0);
        conv(0, 0, 0, 32768, 12, 0);
        conv(0, 0, 0, 65535, 12, 0);
        conv(0, 0, 1, 70000, 12, 0);
        conv(0, 0, 0, 70000, 12, 0);
        conv(0, 0, 1, -9, 12, 0);
        conv(0, 0, 0, -9, 12, 0);
        conv(0, 0, 1, 12345, 12, 0);
        $display("coding test done");
    endtask
    // Low-power mode with the strobe held low restarts after the acquisition count
    task automatic t_auto();
        int n;
        @(posedge ref_clk);
        fast <= 1'b0;
        lp <= 1'b1;
        coding <= 1'b1;
        level <= 18'sh0012c;
        repeat (4) @(posedge ref_clk);
        strobe_n <= 1'b0;
        n = 0;
        while (!busy && n < 10) begin
            @(posedge ref_clk);
            #1 n++;
        end
        n = 0;
        while (busy && n < 5000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        n = 0;
        while (!busy && n < 50) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("auto restart cycles", 16'h0009, 16'(n));
        n = 0;
        while (busy && n < 5000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("auto result", 16'h012c, result);
        @(posedge ref_clk);
        strobe_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        $display("auto restart test done");
    endtask
    task automatic t_stale();
        conv(1, 0, 1, 4660, 10, 0);
        repeat (60) @(posedge ref_clk);
        conv(1, 0, 1, 4661, 10, 1);
        $display("stale test done");
    endtask
    task automatic t_abort();
        @(posedge ref_clk);
        strobe_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b1;
        strobe_n <= 1'b1;
        @(posedge ref_clk);
        #1 chk("abort busy", 16'h0, {hold, busy});
        chk("abort result", 16'h0, result);
        rst <= 1'b0;
        conv(0, 0, 1, 513, 12, 0);
        $display("abort test done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        rst = 1'b1;
        strobe_n = 1'b1;
        fast = 1'b0;
        lp = 1'b0;
        coding = 1'b1;
        level = 18'sh00000;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_codes();
        t_auto();
        t_stale();
        t_abort();
        end_of_test();
    end
endmodule // scc_conversion_control_bench
`default_nettype wire
